/* rtl/flash_host.v */
// Host controller driving the flash pins: status polling and sector protection
// Function
// R1 - Device returns status flags on reads while a program or erase runs.
// R2 - During program, poll bit reads inverse of written bit seven until done.
// R3 - Poll and toggle valid only in program, erase and load delay.
// R4 - During erase poll bit reads 0, then 1 at completion.
// R5 - Host polls erase at an address inside an erasing sector, held stable.
// R6 - Poll bit may change alone; host does one more read for all bits.
// R7 - Toggle alternates while busy; two equal reads mean completion.
// R8 - Toggle may stop early; host does one more read for valid data.
// R9 - Failure flag 1 on pulse-count overrun; poll stays inverted, toggle runs.
// R10 - After failure, no work accepted until host issues reset.
// R11 - Programming a 1 over a 0 raises the time-limit failure.
// R12 - Timer flag reads 0 for 80 us after sector-erase sequence.
// R13 - After delay timer flag reads 1; further sector-erase commands ignored.
// R14 - Host samples timer flag before and after appended sector-erase.
// R15 - Erase status shows timer flag 1; done erase reads all ones.
// R16 - Protected sector unchanged; poll and toggle run 2 to 100 us.
// R17 - Protect: elevated pin and output enable, 100 us write strobe pulse.
// R18 - Protect verify: A0, A6 low, A1 high; reads 01h or 00h.
// R19 - Unprotect: elevated pins, A6 low, A7, A12 high, 10 ms pulse.
// R20 - Host protects every sector before running unprotect.
// R21 - Unprotect verify: A1, A6 high, A0 low; reads 01h or 00h.
// R22 - Sectors ship unprotected; cleared only by unprotect mode.
// R23 - Host issues reset command after failure flag or identification mode.
`timescale 1ns/1ns
`include "flash_host_defs.vh"

module flash_host #(
   parameter PROTECT_CYCLES   = `PROTECT_CYC,
   parameter UNPROTECT_CYCLES = `UNPROTECT_CYC
) (
   input  wire        sys_clk,
   input  wire        srst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [16:0] flash_addr,
   output reg  [7:0]  flash_dq_out,
   output reg         flash_dq_oe,
   input  wire [7:0]  flash_dq_in,
   output reg         chip_enable_n,
   output reg         output_enable_n,
   output reg         write_strobe_n,
   output reg         elevated_select_voltage_oe,
   output reg         high_voltage_address_pin_hv,
   output reg         busy_ff
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam ST_IDLE  = 3'd0;
   localparam ST_SETUP = 3'd1;
   localparam ST_PULSE = 3'd2;
   localparam ST_HOLD  = 3'd3;
   localparam ST_SAMP  = 3'd4;
   localparam ST_CHECK = 3'd5;

   reg [2:0]  state_ff;
   reg [2:0]  cmd_ff;
   reg [16:0] addr_ff;
   reg [7:0]  data_ff;
   reg [7:0]  rdata_ff;
   reg [7:0]  prev_ff;
   reg        have_prev_ff;
   reg        done_ff;
   reg        fail_ff;
   reg        timer_before_ff;
   reg        accepted_ff;
   reg [23:0] cnt_ff;
   reg [7:0]  dq_meta_ff;
   reg [7:0]  dq_sync_ff;

   wire apb_acc = psel & penable;
   wire apb_wr  = apb_acc & pwrite;

   // Counts per pulse kind; verify reads use the short strobe count
   function [23:0] pulse_len;
      input [2:0] c;
      begin
         case (c)
            `CMD_PROTECT:   pulse_len = PROTECT_CYCLES[23:0]; // R17
            `CMD_UNPROTECT: pulse_len = UNPROTECT_CYCLES[23:0]; // R19
            default:        pulse_len = `STROBE_CYC;
         endcase
      end
   endfunction

   function is_write_kind;
      input [2:0] c;
      begin
         is_write_kind = (c == `CMD_WRITE) || (c == `CMD_PROTECT) ||
                         (c == `CMD_UNPROTECT);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Data pin synchroniser: pins are asynchronous to sys_clk
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         dq_meta_ff <= 8'h00;
         dq_sync_ff <= 8'h00;
      end else begin
         dq_meta_ff <= flash_dq_in;
         dq_sync_ff <= dq_meta_ff;
      end
   end

   // ----------------------------------------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel & ~penable) begin
            case (paddr)
               `OFS_CTRL:  prdata <= {29'h0, cmd_ff};
               `OFS_ADDR:  prdata <= {15'h0, addr_ff};
               `OFS_DATA:  prdata <= {24'h0, data_ff};
               `OFS_STAT:  prdata <= {26'h0, accepted_ff, timer_before_ff,
                                      fail_ff, done_ff, 1'b0, busy_ff};
               `OFS_RDATA: prdata <= {24'h0, rdata_ff};
               default:    pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin sequencer
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (srst) begin
         state_ff         <= ST_IDLE;
         cmd_ff           <= `CMD_READ;
         addr_ff          <= 17'h00000;
         data_ff          <= 8'h00;
         rdata_ff         <= 8'h00;
         prev_ff          <= 8'h00;
         have_prev_ff     <= 1'b0;
         done_ff          <= 1'b0;
         fail_ff          <= 1'b0;
         timer_before_ff  <= 1'b0;
         accepted_ff      <= 1'b0;
         cnt_ff           <= 24'h000000;
         busy_ff          <= 1'b0;
         flash_addr       <= 17'h00000;
         flash_dq_out     <= 8'h00;
         flash_dq_oe      <= 1'b0;
         chip_enable_n    <= 1'b1;
         output_enable_n  <= 1'b1;
         write_strobe_n   <= 1'b1;
         elevated_select_voltage_oe  <= 1'b0;
         high_voltage_address_pin_hv <= 1'b0;
      end else begin
         // Registers written only while idle; busy writes are dropped
         if (apb_wr && (state_ff == ST_IDLE) && !busy_ff) begin
            if (paddr == `OFS_ADDR) addr_ff <= pwdata[16:0];
            if (paddr == `OFS_DATA) data_ff <= pwdata[7:0];
            if (paddr == `OFS_CTRL) begin
               cmd_ff   <= pwdata[2:0];
               busy_ff  <= 1'b1;
               done_ff  <= 1'b0;
               if (pwdata[2:0] == `CMD_POLL) begin
                  have_prev_ff <= 1'b0;
                  fail_ff      <= 1'b0;
               end
            end
         end
         case (state_ff)
            ST_IDLE: begin
               if (busy_ff) begin
                  state_ff      <= ST_SETUP;
                  chip_enable_n <= 1'b0;
                  // R5: caller address held for every poll read
                  flash_addr    <= addr_ff;
                  if ((cmd_ff == `CMD_PVERIFY) || (cmd_ff == `CMD_UVERIFY)) begin
                     high_voltage_address_pin_hv <= 1'b1;
                     flash_addr[`A_ZERO] <= 1'b0; // R18
                     flash_addr[`A_SIX]  <= (cmd_ff == `CMD_UVERIFY); // R21
                     flash_addr[`A_ONE]  <= 1'b1;
                  end
                  if (cmd_ff == `CMD_PROTECT) begin
                     high_voltage_address_pin_hv <= 1'b1; // R17
                     elevated_select_voltage_oe  <= 1'b1;
                  end
                  if (cmd_ff == `CMD_UNPROTECT) begin
                     // R20: software protects all sectors beforehand
                     high_voltage_address_pin_hv <= 1'b1; // R19
                     elevated_select_voltage_oe  <= 1'b1;
                     flash_addr[`A_SIX]    <= 1'b0;
                     flash_addr[`A_SEVEN]  <= 1'b1;
                     flash_addr[`A_TWELVE] <= 1'b1;
                  end
                  if (cmd_ff == `CMD_WRITE) begin
                     flash_dq_out <= data_ff;
                     flash_dq_oe  <= 1'b1;
                  end
                  cnt_ff <= `STROBE_CYC;
               end
            end
            ST_SETUP: begin
               if (cnt_ff != 24'h000000) begin
                  cnt_ff <= cnt_ff - 24'h000001;
               end else begin
                  state_ff <= ST_PULSE;
                  cnt_ff   <= pulse_len(cmd_ff);
                  if (is_write_kind(cmd_ff))
                     write_strobe_n <= 1'b0;
                  else if (!elevated_select_voltage_oe)
                     output_enable_n <= 1'b0;
               end
            end
            ST_PULSE: begin
               if (cnt_ff != 24'h000001) begin
                  cnt_ff <= cnt_ff - 24'h000001;
               end else begin
                  // Rising strobe ends protect/unprotect and starts programming
                  write_strobe_n <= 1'b1;
                  state_ff       <= ST_HOLD;
                  cnt_ff         <= `STROBE_CYC;
               end
            end
            ST_HOLD: begin
               // Extra cycles let the two-stage synchroniser settle
               if (cnt_ff != 24'h000000) begin
                  cnt_ff <= cnt_ff - 24'h000001;
               end else begin
                  state_ff <= ST_SAMP;
               end
            end
            ST_SAMP: begin
               rdata_ff        <= dq_sync_ff;
               output_enable_n <= 1'b1;
               chip_enable_n   <= 1'b1;
               flash_dq_oe     <= 1'b0;
               elevated_select_voltage_oe  <= 1'b0;
               high_voltage_address_pin_hv <= 1'b0;
               state_ff <= ST_CHECK;
            end
            ST_CHECK: begin
               state_ff <= ST_IDLE;
               cnt_ff   <= `STROBE_CYC;
               if (cmd_ff == `CMD_POLL) begin
                  if (have_prev_ff &&
                      (prev_ff[`TOGGLE_BIT] == rdata_ff[`TOGGLE_BIT])) begin
                     // R7 R8 R6: stopped toggling; one further read gives valid data
                     cmd_ff  <= `CMD_READ;
                  end else if (have_prev_ff && prev_ff[`FAIL_BIT] &&
                               rdata_ff[`FAIL_BIT]) begin
                     // Two status reads must both flag it: a data read may hold that bit set
                     // R9 R10 R11 R23: failed; software must send the reset sequence
                     fail_ff <= 1'b1;
                     busy_ff <= 1'b0;
                  end
                  prev_ff      <= rdata_ff;
                  have_prev_ff <= 1'b1;
               end else if (cmd_ff == `CMD_TIMER_PROBE) begin
                  // R14: accepted only if timer flag low before and after
                  timer_before_ff <= rdata_ff[`TIMER_BIT];
                  accepted_ff     <= ~rdata_ff[`TIMER_BIT] & ~timer_before_ff;
                  busy_ff         <= 1'b0;
                  done_ff         <= 1'b1;
               end else begin
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

endmodule // flash_host

/* rtl/flash_host_defs.vh */
// Constants for the flash status and sector protection host controller
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// ----------------------------------------------------------------------
// APB register offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_ADDR        12'h004
`define OFS_DATA        12'h008
`define OFS_STAT        12'h00C
`define OFS_RDATA       12'h010

// ----------------------------------------------------------------------
// Command codes in control bits 2:0
// ----------------------------------------------------------------------
`define CMD_READ        3'h0
`define CMD_WRITE       3'h1
`define CMD_POLL        3'h2
`define CMD_PROTECT     3'h3
`define CMD_PVERIFY     3'h4
`define CMD_UNPROTECT   3'h5
`define CMD_UVERIFY     3'h6
`define CMD_TIMER_PROBE 3'h7

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define POLL_BIT        7
`define TOGGLE_BIT      6
`define FAIL_BIT        5
`define TIMER_BIT       3

// ----------------------------------------------------------------------
// Address line positions
// ----------------------------------------------------------------------
`define A_ZERO          0
`define A_ONE           1
`define A_SIX           6
`define A_SEVEN         7
`define A_TWELVE        12

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ         20
`define PROTECT_US      100
`define UNPROTECT_MS    10
`define STROBE_CYC      24'h000004
`define PROTECT_CYC     (`PROTECT_US * `CLK_MHZ)
`define UNPROTECT_CYC   (`UNPROTECT_MS * 1000 * `CLK_MHZ)

`endif

/* sim/flash_host_monitor.sv */
// Checker of the flash host controller pins and bus answer
`timescale 1ns/1ns
module flash_host_monitor #(
   parameter PROTECT_CYCLES   = 8,
   parameter UNPROTECT_CYCLES = 16
) (
   input wire        sys_clk,
   input wire        srst,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire [16:0] flash_addr,
   input wire        flash_dq_oe,
   input wire        chip_enable_n,
   input wire        output_enable_n,
   input wire        write_strobe_n,
   input wire        elevated_select_voltage_oe,
   input wire        high_voltage_address_pin_hv
);
   // ------------------------------------------------------------
   // Strobe length counter and assertions
   // ------------------------------------------------------------
   reg [31:0] low_ff;
   wire       ev;
   assign ev = elevated_select_voltage_oe;
   always @(posedge sys_clk) begin
      if (srst || write_strobe_n)
         low_ff <= 32'h0;
      else
         low_ff <= low_ff + 32'h1;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Read strobe stands through pulse, hold and sample, ten cycles in all
   sequence s_read_first;
      !output_enable_n [*8];
   endsequence
   sequence s_read_pulse;
      s_read_first ##1 !output_enable_n [*2] ##1 output_enable_n;
   endsequence
   a_bus_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_read_pulse: assert property ($fell(output_enable_n) |-> s_read_pulse)
      else $error("read strobe length wrong");
   a_write_pulse: assert property ($rose(write_strobe_n) && !ev |-> low_ff == 32'h4)
      else $error("write strobe length wrong");
   a_protect_pulse: assert property ($rose(write_strobe_n) && ev && !flash_addr[7]
      |-> low_ff == PROTECT_CYCLES) else $error("protect pulse length wrong");
   a_unprotect_pulse: assert property ($rose(write_strobe_n) && ev && flash_addr[7]
      |-> low_ff == UNPROTECT_CYCLES) else $error("unprotect pulse length wrong");
   a_unprotect_lines: assert property (ev && !write_strobe_n && flash_addr[7]
      |-> flash_addr[12] && !flash_addr[6]) else $error("unprotect address wrong");
   a_elevated_pin: assert property (ev |-> high_voltage_address_pin_hv)
      else $error("address pin not elevated");
   a_verify_lines: assert property (high_voltage_address_pin_hv && !ev && !output_enable_n
      |-> !flash_addr[0] && flash_addr[1] && !chip_enable_n && write_strobe_n)
      else $error("verify address wrong");
   a_addr_steady: assert property (!chip_enable_n && !$past(chip_enable_n)
      |-> $stable(flash_addr)) else $error("address moved in access");
   a_no_contention: assert property (!output_enable_n |-> !flash_dq_oe)
      else $error("host drives data during read");
endmodule // flash_host_monitor

/* sim/flash_dev_model.sv */
// Behavioural flash device: program status, failure and sector protection
`timescale 1ns/1ns
module flash_dev_model (
   input wire [16:0] flash_addr,
   input wire [7:0]  flash_dq_out,
   input wire        chip_enable_n,
   input wire        output_enable_n,
   input wire        write_strobe_n,
   input wire        elevated_select_voltage_oe,
   input wire        high_voltage_address_pin_hv,
   output wire [7:0] dq
);
   // ------------------------------------------------------------
   // Array, command state and status
   // ------------------------------------------------------------
   logic [7:0] mem [int];
   logic [7:0] val = 8'h00, pd = 8'h00, prot = 8'h00;
   logic [2:0] cyc = 3'h0;
   logic       tog = 1'b0, fail = 1'b0, ers = 1'b0;
   realtime    t_ld = 0.0;
   int         bsy = 0;
   wire  [2:0] sec = flash_addr[16:14];
   // Released bus shows the inverse so stale data is never taken as valid
   assign dq = (!chip_enable_n && !output_enable_n) ? val : ~val;
   function automatic logic [7:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   // Sector load window is 80 us from the last accepted erase command
   function automatic logic tmr();
      return ($realtime - t_ld) >= 80000.0;
   endfunction
   task automatic wipe(input logic [2:0] s);
      int ks[$];
      if (prot[s]) return;
      foreach (mem[k]) if (k[16:14] == s) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
   endtask
   always @(posedge write_strobe_n) begin
      if (elevated_select_voltage_oe) begin
         if (flash_addr[7] && flash_addr[12] && !flash_addr[6]) prot <= 8'h00;
         else prot[sec] <= 1'b1;
      end else if (!chip_enable_n && flash_dq_out == 8'hF0) begin
         cyc <= 3'h0;
         fail <= 1'b0;
         ers <= 1'b0;
         bsy <= 0;
      end else if (!chip_enable_n && ers && bsy > 0) begin
         // Late appends are dropped once the load window has closed
         if (flash_dq_out == 8'h30 && !tmr()) begin
            t_ld = $realtime;
            wipe(sec);
         end
      end else if (!chip_enable_n && bsy == 0 && !fail) begin
         case (cyc)
            3'h0: cyc <= (flash_dq_out == 8'hAA) ? 3'h1 : 3'h0;
            3'h1: cyc <= (flash_dq_out == 8'h55) ? 3'h2 : 3'h0;
            3'h2: cyc <= (flash_dq_out == 8'hA0) ? 3'h3 :
                         (flash_dq_out == 8'h80) ? 3'h4 : 3'h0;
            3'h4: cyc <= (flash_dq_out == 8'hAA) ? 3'h5 : 3'h0;
            3'h5: cyc <= (flash_dq_out == 8'h55) ? 3'h6 : 3'h0;
            3'h6: begin
               cyc <= 3'h0;
               if (flash_dq_out == 8'h30) begin
                  ers <= 1'b1;
                  bsy <= 3;
                  t_ld = $realtime;
                  wipe(sec);
               end
            end
            default: begin
               cyc <= 3'h0;
               ers <= 1'b0;
               pd <= flash_dq_out;
               bsy <= prot[sec] ? 2 : 3;
               if (|(flash_dq_out & ~rd(flash_addr))) fail <= !prot[sec];
               else if (!prot[sec]) mem[flash_addr] = flash_dq_out;
            end
         endcase
      end
   end
   always @(negedge output_enable_n) begin
      if (high_voltage_address_pin_hv) val <= {7'h00, prot[sec]};
      else if (bsy > 0 || fail) begin
         tog <= ~tog;
         if (ers) val <= {1'b0, ~tog, fail, 1'b0, tmr(), 3'h0};
         else val <= {~pd[7], ~tog, fail, 5'h00};
         // Erase only counts down once the load window has closed
         if (!fail && (!ers || tmr())) bsy <= bsy - 1;
      end else begin
         ers <= 1'b0;
         val <= rd(flash_addr);
      end
   end
endmodule // flash_dev_model

/* sim/testbench.sv */
// Self-checking bench of the flash host controller
`timescale 1ns/1ns
`include "flash_host_defs.vh"
module testbench;
   // ------------------------------------------------------------
   // Signals, instances and tasks
   // ------------------------------------------------------------
   logic        sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire  [31:0] prdata;
   wire  [16:0] flash_addr;
   wire  [7:0]  flash_dq_out, flash_dq_in;
   wire         pready, pslverr, flash_dq_oe, chip_enable_n, output_enable_n;
   wire         write_strobe_n, elevated_select_voltage_oe, high_voltage_address_pin_hv, busy_ff;
   logic [32:0] exp_q[$], msk_q[$];
   int          bad_count = 0, checks_done = 0;
   logic [16:0] pa;
   logic [7:0]  pd;
   logic [2:0]  ps;
   flash_host #(.PROTECT_CYCLES(8), .UNPROTECT_CYCLES(16)) u_flash_host (.sys_clk, .srst,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr,
      .flash_dq_out, .flash_dq_oe, .flash_dq_in, .chip_enable_n, .output_enable_n,
      .write_strobe_n, .elevated_select_voltage_oe, .high_voltage_address_pin_hv, .busy_ff);
   flash_dev_model u_flash_dev_model (.flash_addr, .flash_dq_out, .chip_enable_n,
      .output_enable_n, .write_strobe_n, .elevated_select_voltage_oe,
      .high_voltage_address_pin_hv, .dq(flash_dq_in));
   initial forever #25 sys_clk = ~sys_clk;
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e = 33'h0, input logic [32:0] m = 33'h0);
      if (!w) exp_q.push_back(e);
      if (!w) msk_q.push_back(m);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic check(input logic [32:0] v);
      logic [32:0] e, m;
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      checks_done++;
      if ((v & m) !== (e & m)) begin
         bad_count++;
         $display("wrong value apb read expected %h seen %h", e & m, v & m);
      end
   endtask
   always @(posedge sys_clk)
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata});
   task automatic cmd(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d);
      apb(1'b1, `OFS_ADDR, {15'h0, a});
      apb(1'b1, `OFS_DATA, {24'h0, d});
      apb(1'b1, `OFS_CTRL, {29'h0, c});
      while (busy_ff !== 1'b0) @(posedge sys_clk);
   endtask
   task automatic prog(input logic [16:0] a, input logic [7:0] d);
      cmd(`CMD_WRITE, 17'h05555, 8'hAA);
      cmd(`CMD_WRITE, 17'h02AAA, 8'h55);
      cmd(`CMD_WRITE, 17'h05555, 8'hA0);
      cmd(`CMD_WRITE, a, d);
      cmd(`CMD_POLL, a, 8'h00);
   endtask
   task automatic vfy(input logic [7:0] m);
      for (int s = 0; s < 8; s++) begin
         cmd(`CMD_PVERIFY, {s[2:0], 14'h0000}, 8'h00);
         apb(1'b0, `OFS_RDATA, 32'h0, {32'h0, m[s]}, 33'h1FFFFFFFF);
         cmd(`CMD_UVERIFY, {s[2:0], 14'h0000}, 8'h00);
         apb(1'b0, `OFS_RDATA, 32'h0, {32'h0, m[s]}, 33'h1FFFFFFFF);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Whole run is a few thousand cycles, so this only trips on a hang
   initial begin
      #2000000;
      bad_count++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h45AA));
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, `OFS_STAT, 32'h0, 33'h0, 33'h1FFFFFFFF);
      apb(1'b0, 12'h014, 32'h0, 33'h100000000, 33'h100000000);
      vfy(8'h00);
      ps = 3'($urandom);
      cmd(`CMD_PROTECT, {ps, 14'h0000}, 8'h00);
      vfy(8'h01 << ps);
      pd = 8'($urandom) & 8'h7F;
      pa = {ps + 3'h1, 14'($urandom)};
      prog(pa, pd);
      apb(1'b0, `OFS_RDATA, 32'h0, {25'h0, pd}, 33'h1FFFFFFFF);
      apb(1'b0, `OFS_STAT, 32'h0, 33'h4, 33'hD);
      prog(pa, 8'hFF);
      apb(1'b0, `OFS_STAT, 32'h0, 33'h8, 33'h9);
      cmd(`CMD_WRITE, pa, 8'hF0);
      cmd(`CMD_READ, pa, 8'h00);
      apb(1'b0, `OFS_RDATA, 32'h0, {25'h0, pd}, 33'h1FFFFFFFF);
      prog({ps, 14'h0000}, 8'h00);
      cmd(`CMD_READ, {ps, 14'h0000}, 8'h00);
      apb(1'b0, `OFS_RDATA, 32'h0, 33'hFF, 33'h1FFFFFFFF);
      cmd(`CMD_TIMER_PROBE, {ps, 14'h0000}, 8'h00);
      cmd(`CMD_TIMER_PROBE, {ps, 14'h0000}, 8'h00);
      apb(1'b0, `OFS_STAT, 32'h0, 33'h10, 33'h30);
      cmd(`CMD_WRITE, 17'h05555, 8'hAA);
      cmd(`CMD_WRITE, 17'h02AAA, 8'h55);
      cmd(`CMD_WRITE, 17'h05555, 8'h80);
      cmd(`CMD_WRITE, 17'h05555, 8'hAA);
      cmd(`CMD_WRITE, 17'h02AAA, 8'h55);
      cmd(`CMD_WRITE, pa, 8'h30);
      cmd(`CMD_TIMER_PROBE, pa, 8'h00);
      apb(1'b0, `OFS_RDATA, 32'h0, 33'h0, 33'hA8);
      cmd(`CMD_WRITE, {ps + 3'h2, 14'h0000}, 8'h30);
      cmd(`CMD_TIMER_PROBE, pa, 8'h00);
      apb(1'b0, `OFS_STAT, 32'h0, 33'h20, 33'h30);
      repeat (1700) @(posedge sys_clk);
      cmd(`CMD_TIMER_PROBE, pa, 8'h00);
      apb(1'b0, `OFS_RDATA, 32'h0, 33'h8, 33'hA8);
      cmd(`CMD_POLL, pa, 8'h00);
      apb(1'b0, `OFS_RDATA, 32'h0, 33'hFF, 33'h1FFFFFFFF);
      for (int s = 0; s < 8; s++) cmd(`CMD_PROTECT, {s[2:0], 14'h0000}, 8'h00);
      vfy(8'hFF);
      cmd(`CMD_UNPROTECT, 17'h01080, 8'h00);
      vfy(8'h00);
      end_of_test;
   end
endmodule // testbench
bind flash_host flash_host_monitor #(.PROTECT_CYCLES(PROTECT_CYCLES),
   .UNPROTECT_CYCLES(UNPROTECT_CYCLES)) u_flash_host_monitor (.sys_clk, .srst, .psel,
   .penable, .pready, .flash_addr, .flash_dq_oe, .chip_enable_n, .output_enable_n,
   .write_strobe_n, .elevated_select_voltage_oe, .high_voltage_address_pin_hv);
